// file: rtl/timer16_consts.svh
// Offsets, field positions, reset values and fixed counts of the timer
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

`define ADDR_W           4
`define DATA_W           8
`define CNT_W            16

// Register offsets (byte-wide registers)
`define OFS_CTRL_A       4'h0
`define OFS_CTRL_B       4'h1
`define OFS_FORCE        4'h2
`define OFS_ROUTE        4'h3
`define OFS_CNT_LOW      4'h4
`define OFS_CNT_HIGH     4'h5
`define OFS_CMPA_LOW     4'h6
`define OFS_CMPA_HIGH    4'h7
`define OFS_CMPB_LOW     4'h8
`define OFS_CMPB_HIGH    4'h9
`define OFS_IRQ_EN       4'ha
`define OFS_FLAGS        4'hb
`define OFS_PORT         4'hc

// Field positions
`define CTRLA_ACT_A_LSB  0
`define CTRLA_ACT_B_LSB  2
`define CTRLA_WGM_LSB    4
`define CTRLB_WGM_LSB    0
`define CTRLB_RUN_BIT    2
`define FLAG_OVF_BIT     2
`define PORT_DIR_LSB     2

// Reset values
`define RST_BYTE         8'h00
`define RST_CNT          16'h0000

// Counter extremes and fixed tops
`define CNT_MAX          16'hffff
`define CNT_BOTTOM       16'h0000
`define TOP_8BIT         16'h00ff
`define TOP_9BIT         16'h01ff
`define TOP_10BIT        16'h03ff

// Output actions
`define ACT_NONE         2'h0
`define ACT_TOGGLE       2'h1
`define ACT_CLEAR        2'h2
`define ACT_SET          2'h3

// Timer clock divider default
`define TICK_DIV         16'h0001

`endif

// file: rtl/timer16_pkg.sv
// Types shared by the timer compare block
package timer16_pkg;
  `include "timer16_consts.svh"

  typedef logic [3:0] wave_mode_t;

  typedef struct packed {
    logic [`CNT_W-1:0]  cnt;
    logic               down;
    logic [`DATA_W-1:0] temp;
    wave_mode_t         wgm;
    logic [1:0][1:0]    act;
    logic               run;
    logic [1:0]         route;
    logic [1:0]         port_out;
    logic [1:0]         port_dir;
    logic [2:0]         irq_en;
    logic               ovf_flag;
    logic               block;
    logic [`DATA_W-1:0] rdata;
  } tmr_state_t;

  typedef struct packed {
    logic [`CNT_W-1:0] active;
    logic [`CNT_W-1:0] buffer;
    logic              state;
    logic              match_q;
    logic              match_dn_q;
    logic              flag;
  } oc_state_t;

  typedef struct packed {
    logic [15:0] cnt;
  } div_state_t;
endpackage

// file: rtl/tick_divider.sv
// Divider producing the one-cycle timer clock enable
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"
module tick_divider
  import timer16_pkg::*;
#(
  parameter logic [15:0] DIV = `TICK_DIV
) (
  input  wire logic i_clk,     // System clock
  input  wire logic i_sys_rst, // Synchronous reset
  output logic      o_tick     // One-cycle enable
);
  div_state_t s_reg;
  div_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt >= DIV - 16'h0001) begin
      s_next.cnt = 16'h0000;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  // DIV of one gives an enable on every clock
  assign o_tick = (s_reg.cnt >= DIV - 16'h0001);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// file: rtl/oc_channel.sv
// One output compare channel: comparator, buffer, flag and output state
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"
module oc_channel
  import timer16_pkg::*;
(
  input  wire logic              i_clk,     // System clock
  input  wire logic              i_sys_rst, // Synchronous reset
  input  wire logic              i_tick,    // Timer clock enable
  input  wire logic              i_block,   // Suppress match this tick
  input  wire logic [`CNT_W-1:0] i_cnt,     // Counter value
  input  wire logic              i_pwm,     // PWM mode, buffered
  input  wire logic              i_dual,    // Dual-slope PWM
  input  wire logic              i_down,    // Counting down
  input  wire logic              i_clr_top, // Single-slope PWM clear
  input  wire logic              i_update,  // Buffer to active
  input  wire logic              i_wr_low,  // Low-byte write
  input  wire logic [`CNT_W-1:0] i_wdata,   // Latched high and low
  input  wire logic [1:0]        i_action,  // Output action
  input  wire logic              i_force,   // Force strobe
  input  wire logic              i_clr,     // Flag write-one clear
  input  wire logic              i_ack,     // Interrupt serviced
  output logic [`CNT_W-1:0]      o_value,   // Value seen by the CPU
  output logic [`CNT_W-1:0]      o_active,  // Active compare value
  output logic                   o_state,   // Output state
  output logic                   o_flag     // Match flag
);
  oc_state_t s_reg;
  oc_state_t s_next;
  logic      match;
  logic      set_flag;

  assign match = (i_cnt == s_reg.active);

  always_comb begin
    s_next   = s_reg;
    set_flag = 1'b0;
    if (i_tick) begin
      s_next.match_q    = match & ~i_block;
      s_next.match_dn_q = i_down;
      set_flag          = s_reg.match_q;
      // Top action first so a match on the same tick has the last word
      if (i_clr_top) begin
        if (i_action == `ACT_CLEAR) begin
          s_next.state = 1'b0;
        end else if (i_action == `ACT_SET) begin
          s_next.state = 1'b1;
        end
      end
      if (s_reg.match_q) begin
        unique case (i_action)
          `ACT_NONE: s_next.state = s_next.state;
          `ACT_TOGGLE: begin
            if (!i_pwm) begin
              s_next.state = ~s_reg.state;
            end
          end
          `ACT_CLEAR: begin
            s_next.state = i_dual ? s_reg.match_dn_q : ~i_pwm;
          end
          `ACT_SET: begin
            s_next.state = i_dual ? ~s_reg.match_dn_q : i_pwm;
          end
        endcase
      end
    end
    if (i_force && !i_pwm) begin
      unique case (i_action)
        `ACT_NONE:   s_next.state = s_reg.state;
        `ACT_TOGGLE: s_next.state = ~s_reg.state;
        `ACT_CLEAR:  s_next.state = 1'b0;
        `ACT_SET:    s_next.state = 1'b1;
      endcase
    end
    // Set beats a clear in the same cycle
    s_next.flag = (s_reg.flag & ~i_clr & ~i_ack) | set_flag;
    if (i_update && i_pwm) begin
      s_next.active = s_reg.buffer;
    end
    if (i_wr_low) begin
      if (i_pwm) begin
        s_next.buffer = i_wdata;
      end else begin
        s_next.active = i_wdata;
      end
    end
  end

  assign o_value  = i_pwm ? s_reg.buffer : s_reg.active;
  assign o_active = s_reg.active;
  assign o_state  = s_reg.state;
  assign o_flag   = s_reg.flag;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// file: rtl/timer16_output_compare.sv
// Timer16 counter with two output compare channels and byte register port
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"
module timer16_output_compare
  import timer16_pkg::*;
#(
  parameter logic [15:0] TICK_DIV = `TICK_DIV
) (
  input  wire logic               i_clk,         // 40 MHz system clock
  input  wire logic               i_sys_rst,     // Sync reset, active high
  input  wire logic [`ADDR_W-1:0] i_addr,        // Register address
  input  wire logic [`DATA_W-1:0] i_wdata,       // Write data
  input  wire logic               i_wr,          // Write strobe
  input  wire logic               i_rd,          // Read strobe
  output logic      [`DATA_W-1:0] o_rdata,       // Read data, next cycle
  input  wire logic [`CNT_W-1:0]  i_capture_top, // Capture value as TOP
  input  wire logic               i_ack_cmp_a,   // Channel A irq serviced
  input  wire logic               i_ack_cmp_b,   // Channel B irq serviced
  input  wire logic               i_ack_ovf,     // Overflow irq serviced
  output logic                    o_irq_cmp_a,   // Channel A request
  output logic                    o_irq_cmp_b,   // Channel B request
  output logic                    o_irq_ovf,     // Overflow request
  output logic      [1:0]         o_pin,         // Compare output pins
  output logic      [1:0]         o_pin_oe       // Pin drive enables
);
  tmr_state_t        s_reg;
  tmr_state_t        s_next;

  logic              tick;
  logic              tclk;
  logic              pwm;
  logic              dual;
  logic              upd_bottom;
  logic              ovf_at_max;
  logic [`CNT_W-1:0] top;
  logic              at_top;
  logic              at_bottom;
  logic              update;
  logic              clr_top;
  logic              cnt_wr;
  logic              ovf_set;
  logic [1:0]        wr_low;
  logic [1:0]        force_cmp;
  logic [1:0]        flag_clr;
  logic [1:0]        ack;
  logic [1:0]        state;
  logic [1:0]        flag;
  logic [`CNT_W-1:0] value  [2];
  logic [`CNT_W-1:0] active [2];

  tick_divider #(
    .DIV (TICK_DIV)
  ) u_div (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .o_tick    (tick)
  );

  // Stopped timer gives no timer clock, but writes still work
  assign tclk = tick & s_reg.run;

  // Mode decode: 0, 4, 12 and reserved 13 are the unbuffered modes
  always_comb begin
    pwm        = 1'b1;
    dual       = 1'b0;
    upd_bottom = 1'b0;
    ovf_at_max = 1'b0;
    top        = `CNT_MAX;
    unique case (s_reg.wgm)
      4'd0: begin
        pwm        = 1'b0;
        ovf_at_max = 1'b1;
      end
      4'd1: begin
        dual = 1'b1;
        top  = `TOP_8BIT;
      end
      4'd2: begin
        dual = 1'b1;
        top  = `TOP_9BIT;
      end
      4'd3: begin
        dual = 1'b1;
        top  = `TOP_10BIT;
      end
      4'd4: begin
        pwm        = 1'b0;
        ovf_at_max = 1'b1;
        top        = active[0];
      end
      4'd5: begin
        top = `TOP_8BIT;
      end
      4'd6: begin
        top = `TOP_9BIT;
      end
      4'd7: begin
        top = `TOP_10BIT;
      end
      4'd8: begin
        dual       = 1'b1;
        upd_bottom = 1'b1;
        top        = i_capture_top;
      end
      4'd9: begin
        dual       = 1'b1;
        upd_bottom = 1'b1;
        top        = active[0];
      end
      4'd10: begin
        dual = 1'b1;
        top  = i_capture_top;
      end
      4'd11: begin
        dual = 1'b1;
        top  = active[0];
      end
      4'd12: begin
        pwm        = 1'b0;
        ovf_at_max = 1'b1;
        top        = i_capture_top;
      end
      4'd13: begin
        pwm        = 1'b0;
        ovf_at_max = 1'b1;
      end
      4'd14: begin
        top = i_capture_top;
      end
      4'd15: begin
        top = active[0];
      end
    endcase
  end

  assign at_top    = (s_reg.cnt == top);
  assign at_bottom = (s_reg.cnt == `CNT_BOTTOM);

  // Buffered values move only at a sequence extreme
  assign update  = tclk & (upd_bottom ? (s_reg.down & at_bottom)
                                      : at_top);
  assign clr_top = tclk & pwm & ~dual & at_top;

  // Overflow in normal-like modes is the step from MAX to zero
  // A counter write wins the tick, so no count reaches zero then
  assign ovf_set = tclk & ~cnt_wr
                   & (ovf_at_max ? (s_reg.cnt == `CNT_MAX)
                   : dual ? (s_reg.down & at_bottom) : at_top);

  assign cnt_wr = i_wr & (i_addr == `OFS_CNT_LOW);

  always_comb begin
    wr_low[0]    = i_wr & (i_addr == `OFS_CMPA_LOW);
    wr_low[1]    = i_wr & (i_addr == `OFS_CMPB_LOW);
    force_cmp    = (i_wr && i_addr == `OFS_FORCE) ? i_wdata[1:0] : 2'b00;
    flag_clr     = (i_wr && i_addr == `OFS_FLAGS) ? i_wdata[1:0] : 2'b00;
    ack          = {i_ack_cmp_b, i_ack_cmp_a};
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      oc_channel u_ch (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_tick    (tclk),
        .i_block   (s_reg.block),
        .i_cnt     (s_reg.cnt),
        .i_pwm     (pwm),
        .i_dual    (dual),
        .i_down    (s_reg.down),
        .i_clr_top (clr_top),
        .i_update  (update),
        .i_wr_low  (wr_low[g]),
        .i_wdata   ({s_reg.temp, i_wdata}),
        .i_action  (s_reg.act[g]),
        .i_force   (force_cmp[g]),
        .i_clr     (flag_clr[g]),
        .i_ack     (ack[g]),
        .o_value   (value[g]),
        .o_active  (active[g]),
        .o_state   (state[g]),
        .o_flag    (flag[g])
      );
      // Port pin takes the output state only when routed
      assign o_pin[g] = (s_reg.act[g] != `ACT_NONE && s_reg.route[g])
                        ? state[g] : s_reg.port_out[g];
      assign o_pin_oe[g] = s_reg.port_dir[g];
    end
  endgenerate

  always_comb begin
    s_next       = s_reg;
    s_next.rdata = `RST_BYTE;

    // Counter: CPU write wins over count and clear
    if (cnt_wr) begin
      s_next.cnt   = {s_reg.temp, i_wdata};
      s_next.block = 1'b1;
    end else if (tclk) begin
      s_next.block = 1'b0;
      // Plain equality; a write landing above TOP runs on
      if (dual) begin
        if (!s_reg.down) begin
          if (at_top) begin
            s_next.down = 1'b1;
            s_next.cnt  = s_reg.cnt - 16'h0001;
          end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
          end
        end else if (at_bottom) begin
          s_next.down = 1'b0;
          s_next.cnt  = s_reg.cnt + 16'h0001;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end else begin
        // Normal wraps by itself since its top is MAX
        s_next.down = 1'b0;
        s_next.cnt  = at_top ? `CNT_BOTTOM
                             : s_reg.cnt + 16'h0001;
      end
    end

    // Overflow flag: set by hardware, cleared by service or by writing one
    s_next.ovf_flag = (s_reg.ovf_flag & ~i_ack_ovf
                       & ~(i_wr && i_addr == `OFS_FLAGS
                           && i_wdata[`FLAG_OVF_BIT]))
                      | ovf_set;

    if (i_wr) begin
      unique case (i_addr)
        `OFS_CTRL_A: begin
          s_next.act[0]      = i_wdata[`CTRLA_ACT_A_LSB +: 2];
          s_next.act[1]      = i_wdata[`CTRLA_ACT_B_LSB +: 2];
          s_next.wgm[1:0]    = i_wdata[`CTRLA_WGM_LSB +: 2];
        end
        `OFS_CTRL_B: begin
          s_next.wgm[3:2] = i_wdata[`CTRLB_WGM_LSB +: 2];
          s_next.run      = i_wdata[`CTRLB_RUN_BIT];
        end
        `OFS_ROUTE: begin
          s_next.route = i_wdata[1:0];
        end
        `OFS_CNT_HIGH,
        `OFS_CMPA_HIGH,
        `OFS_CMPB_HIGH: begin
          s_next.temp = i_wdata;
        end
        `OFS_IRQ_EN: begin
          s_next.irq_en = i_wdata[2:0];
        end
        `OFS_PORT: begin
          s_next.port_out = i_wdata[1:0];
          s_next.port_dir = i_wdata[`PORT_DIR_LSB +: 2];
        end
        default: begin
          s_next.temp = s_reg.temp;
        end
      endcase
    end

    if (i_rd) begin
      unique case (i_addr)
        `OFS_CTRL_A: begin
          s_next.rdata = {2'b00, s_reg.wgm[1:0], s_reg.act[1], s_reg.act[0]};
        end
        `OFS_CTRL_B: begin
          s_next.rdata = {5'h00, s_reg.run, s_reg.wgm[3:2]};
        end
        `OFS_FORCE: begin
          s_next.rdata = `RST_BYTE;
        end
        `OFS_ROUTE: begin
          s_next.rdata = {6'h00, s_reg.route};
        end
        `OFS_CNT_LOW: begin
          s_next.rdata = s_reg.cnt[7:0];
          s_next.temp  = s_reg.cnt[15:8];
        end
        `OFS_CNT_HIGH: begin
          s_next.rdata = s_reg.temp;
        end
        `OFS_CMPA_LOW: begin
          s_next.rdata = value[0][7:0];
        end
        `OFS_CMPA_HIGH: begin
          s_next.rdata = value[0][15:8];
        end
        `OFS_CMPB_LOW: begin
          s_next.rdata = value[1][7:0];
        end
        `OFS_CMPB_HIGH: begin
          s_next.rdata = value[1][15:8];
        end
        `OFS_IRQ_EN: begin
          s_next.rdata = {5'h00, s_reg.irq_en};
        end
        `OFS_FLAGS: begin
          s_next.rdata = {5'h00, s_reg.ovf_flag, flag};
        end
        `OFS_PORT: begin
          s_next.rdata = {4'h0, s_reg.port_dir, s_reg.port_out};
        end
        default: begin
          s_next.rdata = `RST_BYTE;
        end
      endcase
    end
  end

  // Capture logic lives elsewhere; the action field has no path to it
  assign o_irq_cmp_a = flag[0] & s_reg.irq_en[0];
  assign o_irq_cmp_b = flag[1] & s_reg.irq_en[1];
  assign o_irq_ovf   = s_reg.ovf_flag & s_reg.irq_en[2];
  assign o_rdata     = s_reg.rdata;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// file: verif/timer16_oc_props.sv
// Port-level checks of the timer compare block
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"
module timer16_oc_props (
  input wire logic               i_clk,       // System clock
  input wire logic               i_sys_rst,   // Sync reset
  input wire logic [`ADDR_W-1:0] i_addr,      // Register address
  input wire logic [`DATA_W-1:0] i_wdata,     // Write data
  input wire logic               i_wr,        // Write strobe
  input wire logic               i_rd,        // Read strobe
  input wire logic [`DATA_W-1:0] o_rdata,     // Read data
  input wire logic               i_ack_cmp_b, // Channel B serviced
  input wire logic               o_irq_cmp_b, // Channel B request
  input wire logic               o_irq_ovf,   // Overflow request
  input wire logic [1:0]         o_pin,       // Compare pins
  input wire logic [1:0]         o_pin_oe     // Pin enables
);
  logic [3:0] act_reg;
  logic [3:0] mode_reg;
  logic [1:0] route_reg;
  logic [1:0] port_reg;
  logic       force_a;

  // Shadow of CPU writes, so the pin source is judged from the bus alone
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      act_reg   <= 4'h0;
      mode_reg  <= 4'h0;
      route_reg <= 2'h0;
      port_reg  <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == `OFS_CTRL_A) begin
        act_reg       <= i_wdata[3:0];
        mode_reg[1:0] <= i_wdata[5:4];
      end
      if (i_addr == `OFS_CTRL_B) mode_reg[3:2] <= i_wdata[1:0];
      if (i_addr == `OFS_ROUTE) route_reg <= i_wdata[1:0];
      if (i_addr == `OFS_PORT) port_reg <= i_wdata[1:0];
    end
  end

  assign force_a = i_wr && i_addr == `OFS_FORCE && i_wdata[0] && route_reg[0]
                   && act_reg[1:0] == `ACT_TOGGLE
                   && (mode_reg == 4'h0 || mode_reg == 4'h4);

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_force_read_zero;
    i_rd && i_addr == `OFS_FORCE |=> o_rdata == 8'h00;
  endproperty
  a_force_read_zero: assert property (p_force_read_zero)
    else $error("force register read not zero");
  property p_force_toggle;
    force_a |=> o_pin[0] != $past(o_pin[0]);
  endproperty
  a_force_toggle: assert property (p_force_toggle)
    else $error("forced toggle did not reach pin A");
  property p_pin_a_port;
    !(route_reg[0] && act_reg[1:0] != `ACT_NONE) |-> o_pin[0] == port_reg[0];
  endproperty
  a_pin_a_port: assert property (p_pin_a_port)
    else $error("pin A not from port output");
  property p_pin_b_port;
    !(route_reg[1] && act_reg[3:2] != `ACT_NONE) |-> o_pin[1] == port_reg[1];
  endproperty
  a_pin_b_port: assert property (p_pin_b_port)
    else $error("pin B not from port output");
  property p_oe_follows;
    i_wr && i_addr == `OFS_PORT |=> o_pin_oe == $past(i_wdata[3:2]);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("pin enable not from direction bits");
  property p_oe_hold;
    !(i_wr && i_addr == `OFS_PORT) |=> $stable(o_pin_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("pin enable moved without a write");
  property p_ack_clears;
    i_ack_cmp_b && o_irq_cmp_b |=> !o_irq_cmp_b;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("service did not clear channel B request");
  property p_w1c_ovf;
    i_wr && i_addr == `OFS_FLAGS && i_wdata[`FLAG_OVF_BIT] |=> !o_irq_ovf;
  endproperty
  a_w1c_ovf: assert property (p_w1c_ovf)
    else $error("write one did not clear overflow");
  property p_irq_en_off;
    i_wr && i_addr == `OFS_IRQ_EN && i_wdata[2:1] == 2'h0
      |=> !o_irq_ovf ##1 !o_irq_cmp_b;
  endproperty
  a_irq_en_off: assert property (p_irq_en_off)
    else $error("request with enable off");
endmodule
bind timer16_output_compare timer16_oc_props u_props (
  .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_ack_cmp_b, .o_irq_cmp_b, .o_irq_ovf, .o_pin, .o_pin_oe
);
`default_nettype wire

// file: verif/cpu_model.sv
// Interrupt-servicing side of the CPU core
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
  parameter int LAT = 2
) (
  input  wire logic       i_clk,     // System clock
  input  wire logic       i_sys_rst, // Sync reset
  input  wire logic       i_en,      // Global interrupt enable
  input  wire logic [2:0] i_irq,     // Pending requests
  output logic      [2:0] o_ack      // Service pulses
);
  int wait_reg;

  // One vector at a time, lowest first, after a response delay
  always_ff @(posedge i_clk) begin
    o_ack <= 3'h0;
    if (i_sys_rst || !i_en || i_irq == 3'h0 || o_ack != 3'h0) begin
      wait_reg <= 0;
    end else if (wait_reg < LAT) begin
      wait_reg <= wait_reg + 1;
    end else begin
      o_ack    <= i_irq & (~i_irq + 3'h1);
      wait_reg <= 0;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Register-level testbench of the timer compare block
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"
module tb;
  logic               clk;
  logic               sys_rst;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wdata;
  logic               wr;
  logic               rd;
  logic [15:0]        cap_top;
  logic               cpu_en;
  logic [7:0]         b;
  logic [15:0]        v;
  wire logic [7:0]    rdata;
  wire logic [2:0]    ack;
  wire logic [2:0]    irq;
  wire logic [1:0]    pin;
  wire logic [1:0]    pin_oe;
  int                 n_mismatch;
  int                 num_checks;
  int                 i;

  timer16_output_compare #(.TICK_DIV(16'h0001)) dut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_capture_top(cap_top),
    .i_ack_cmp_a(ack[0]), .i_ack_cmp_b(ack[1]), .i_ack_ovf(ack[2]),
    .o_irq_cmp_a(irq[0]), .o_irq_cmp_b(irq[1]), .o_irq_ovf(irq[2]),
    .o_pin(pin), .o_pin_oe(pin_oe)
  );
  cpu_model #(.LAT(3)) u_cpu (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_en(cpu_en), .i_irq(irq),
    .o_ack(ack)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // High byte goes first into the shared latch
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr_reg(a + 4'h1, d[15:8]);
    wr_reg(a, d[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    rd_reg(a, lo);
    rd_reg(a + 4'h1, hi);
    d = {hi, lo};
  endtask
  task automatic wait_irq(input int k, input logic lvl, input int lim);
    int n;
    // Look just after the edge, once the request has settled
    for (n = 0; n < lim && irq[k] !== lvl; n++) begin
      @(posedge clk);
      #1;
    end
    check({15'h0, irq[k]}, {15'h0, lvl});
    if (irq[k] !== lvl) print_verdict();
  endtask

  initial begin
    sys_rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cap_top = 16'h0000;
    cpu_en = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    idle(5);
    sys_rst <= 1'b0;
    wr_reg(4'he, 8'hff);
    for (i = 0; i < 16; i++) begin
      rd_reg(i[3:0], b);
      check({8'h00, b}, {8'h00, `RST_BYTE});
    end
    wr_reg(`OFS_ROUTE, 8'h03);
    wr_reg(`OFS_PORT, 8'h0f);
    wr_reg(`OFS_CTRL_A, 8'h01);
    check({14'h0, pin}, 16'h0002);
    check({14'h0, pin_oe}, 16'h0003);
    wr_reg(`OFS_FORCE, 8'h01);
    check({14'h0, pin}, 16'h0003);
    rd_reg(`OFS_FORCE, b);
    check({8'h00, b}, 16'h0000);
    rd_reg(`OFS_FLAGS, b);
    check({8'h00, b}, 16'h0000);
    rd16(`OFS_CNT_LOW, v);
    check(v, 16'h0000);
    wr_reg(`OFS_CTRL_A, 8'h11);
    wr_reg(`OFS_CTRL_A, 8'h01);
    check({14'h0, pin}, 16'h0003);
    wr_reg(`OFS_CTRL_A, 8'h00);
    wr_reg(`OFS_FORCE, 8'h01);
    wr_reg(`OFS_PORT, 8'h0c);
    wr_reg(`OFS_CTRL_A, 8'h0d);
    check({14'h0, pin}, 16'h0001);
    wr_reg(`OFS_FORCE, 8'h02);
    check({14'h0, pin}, 16'h0003);
    wr16(`OFS_CMPA_LOW, 16'habcd);
    rd_reg(`OFS_CMPA_HIGH, b);
    check({8'h00, b}, 16'h00ab);
    wr_reg(`OFS_CNT_HIGH, 8'h12);
    wr_reg(`OFS_CMPB_LOW, 8'h34);
    rd16(`OFS_CMPB_LOW, v);
    check(v, 16'h1234);
    rd16(`OFS_CMPA_LOW, v);
    check(v, 16'habcd);
    // Counter equal to compare A at start: that match must be swallowed
    wr_reg(`OFS_CTRL_A, 8'h00);
    wr_reg(`OFS_IRQ_EN, 8'h07);
    wr16(`OFS_CMPA_LOW, 16'h0005);
    wr16(`OFS_CMPB_LOW, 16'h0009);
    wr16(`OFS_CNT_LOW, 16'h0005);
    wr_reg(`OFS_CTRL_B, 8'h04);
    idle(12);
    wr_reg(`OFS_CTRL_B, 8'h00);
    check({13'h0, irq}, 16'h0002);
    @(posedge clk);
    cpu_en <= 1'b1;
    wait_irq(1, 1'b0, 20);
    @(posedge clk);
    cpu_en <= 1'b0;
    rd_reg(`OFS_FLAGS, b);
    check({8'h00, b}, 16'h0000);
    wr16(`OFS_CNT_LOW, 16'hfffd);
    wr_reg(`OFS_CTRL_B, 8'h04);
    wait_irq(2, 1'b1, 20);
    idle(10);
    wr_reg(`OFS_CTRL_B, 8'h00);
    check({15'h0, irq[2]}, 16'h0001);
    rd16(`OFS_CNT_LOW, v);
    check({15'h0, v > 16'h0009 && v < 16'h0020}, 16'h0001);
    wr_reg(`OFS_FLAGS, 8'h04);
    check({15'h0, irq[2]}, 16'h0000);
    wr_reg(`OFS_CTRL_B, 8'h04);
    wr16(`OFS_CNT_LOW, 16'h4200);
    wr_reg(`OFS_CTRL_B, 8'h00);
    rd16(`OFS_CNT_LOW, v);
    check({8'h00, v[15:8]}, 16'h0042);
    // Mode 14: compare B write sits in the buffer until TOP
    @(posedge clk);
    cap_top <= 16'h0020;
    wr_reg(`OFS_CTRL_A, 8'h20);
    wr_reg(`OFS_CTRL_B, 8'h03);
    wr_reg(`OFS_FLAGS, 8'h07);
    wr16(`OFS_CNT_LOW, 16'h000a);
    wr16(`OFS_CMPB_LOW, 16'h000c);
    rd16(`OFS_CMPB_LOW, v);
    check(v, 16'h000c);
    wr_reg(`OFS_CTRL_B, 8'h07);
    idle(10);
    check({15'h0, irq[1]}, 16'h0000);
    wait_irq(1, 1'b1, 80);
    wr_reg(`OFS_CTRL_B, 8'h03);
    wr_reg(`OFS_IRQ_EN, 8'h00);
    check({13'h0, irq}, 16'h0000);
    // Mode 4: compare A is TOP, so the counter never passes it
    wr_reg(`OFS_CTRL_A, 8'h00);
    wr_reg(`OFS_CTRL_B, 8'h01);
    wr16(`OFS_CMPA_LOW, 16'h0003);
    wr16(`OFS_CNT_LOW, 16'h0000);
    wr_reg(`OFS_CTRL_B, 8'h05);
    idle(20);
    wr_reg(`OFS_CTRL_B, 8'h01);
    rd16(`OFS_CNT_LOW, v);
    check({15'h0, v < 16'h0004}, 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
